// file: pkg/ocd_pkg.sv
// Constants and types for the opcode command decoder.
// Assumes a 125 MHz ref_clk and a serial link sampled by that clock.
package ocd_pkg;
	localparam int CLK_NS = 8;
	// Execution, register and flash opcodes
	localparam logic [7:0] OP_UP     = 8'h00;
	localparam logic [7:0] OP_DN     = 8'h01;
	localparam logic [7:0] OP_DIFF   = 8'h02;
	localparam logic [7:0] OP_TEMP   = 8'h03;
	localparam logic [7:0] OP_RESET  = 8'h04;
	localparam logic [7:0] OP_INIT   = 8'h05;
	localparam logic [7:0] OP_SAVE   = 8'h06;
	localparam logic [7:0] OP_AUX_LO = 8'h07;
	localparam logic [7:0] OP_AUX_HI = 8'h0E;
	localparam logic [7:0] OP_WR_LO  = 8'h30;
	localparam logic [7:0] OP_WR_HI  = 8'h43;
	localparam logic [7:0] OP_RD_LO  = 8'hB0;
	localparam logic [7:0] OP_FL_RD  = 8'h90;
	localparam logic [7:0] OP_FL_WR  = 8'h10;
	localparam logic [7:0] OP_FL_ER  = 8'h13;
	// Register space seen by read opcodes and the local port
	localparam int         CFG_N       = 20;
	localparam int         RES_N       = 11;
	localparam logic [7:0] CFG_RD_BASE = 8'hB0;
	localparam logic [7:0] RES_RD_BASE = 8'hC4;
	localparam logic [7:0] RES_RD_END  = 8'hCF;
	localparam logic [7:0] STAT_ADDR   = 8'hFE;
	localparam logic [15:0] CFG_RST    = 16'h0000;
	localparam logic [15:0] RES_RST    = 16'h0000;
	localparam logic [15:0] STAT_RST   = 16'h0000;
	// Configuration words and fields
	localparam int CFG_SPACING_IDX = 1;
	localparam int SPACING_LSB     = 0;
	localparam int CFG_CTRL_IDX    = 19;
	localparam int ALERT_EN_BIT    = 0;
	// Result word indices
	localparam int RES_UP_HIT   = 0;
	localparam int RES_UP_MEAN  = 1;
	localparam int RES_UP_RATIO = 2;
	localparam int RES_DN_HIT   = 3;
	localparam int RES_DN_MEAN  = 4;
	localparam int RES_DN_RATIO = 5;
	localparam int RES_DELTA    = 6;
	localparam int RES_TEMP0    = 7;
	// Status flag positions
	localparam int FLG_FLIGHT  = 0;
	localparam int FLG_THERMAL = 1;
	localparam int FLG_SETUP   = 2;
	localparam int FLG_SAVE    = 3;
	localparam int FLG_AUX     = 4;
	// Spacing unit between the two starts of a differential run
	localparam int          SPACE_UNIT_NS  = 1000;
	localparam logic [15:0] SPACE_UNIT_CYC = 16'((SPACE_UNIT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [12:0] FLASH_ADDR_RST = 13'h0000;

	typedef enum logic [2:0] {ST_IDLE, ST_UP, ST_WAIT, ST_DN, ST_TEMP, ST_AUX} ocd_state_t;
	typedef enum logic [1:0] {FL_READ, FL_WRITE, FL_ERASE} ocd_flash_op_t;
endpackage

// file: pkg/ocd_link_if.sv
// Carrier between the serial front end and the command core.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface ocd_link_if;
	logic [7:0]  cmd;      // Opcode of the current frame
	logic        exec_stb; // Frame closed after exactly 8 bits
	logic        wr_stb;   // One 16-bit word received
	logic        wr_first; // Word is the first after the opcode
	logic [7:0]  addr;     // Register address of current word
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic        rd_take;  // Word at addr loaded for shifting out
	modport spi (output cmd, exec_stb, wr_stb, wr_first, addr, wr_data, rd_take, input rd_data);
	modport core (input cmd, exec_stb, wr_stb, wr_first, addr, wr_data, rd_take, output rd_data);
endinterface
`default_nettype wire

// file: core/ocd_spi_rx.sv
// Serial link front end: synchronises the pins, frames opcodes and words.
// Assumes the link clock is far slower than ref_clk (several cycles per phase).
`timescale 1ns/1ps
`default_nettype none
module ocd_spi_rx
	import ocd_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic spi_sck,
	input  wire logic spi_din,
	input  wire logic spi_ce_n,
	output var  logic spi_dout,
	ocd_link_if.spi   lnk
);
	logic [1:0]  sck_s_q;
	logic [1:0]  din_s_q;
	logic [1:0]  ce_s_q;
	logic        sck_p_q;
	logic        ce_p_q;
	logic [3:0]  bit_q;
	logic [3:0]  txcnt_q;
	logic [15:0] sh_q;
	logic [15:0] tx_q;
	logic        cmd_done_q;
	logic        extra_q;

	// Edge and phase decode on synchronised pins
	wire logic       sck_fall    = sck_p_q & ~sck_s_q[1];
	wire logic       sck_rise    = ~sck_p_q & sck_s_q[1];
	wire logic       ce_act      = ~ce_s_q[1];
	wire logic       frame_start = ce_p_q & ~ce_s_q[1];
	wire logic       frame_end   = ~ce_p_q & ce_s_q[1];
	wire logic       is_read     = lnk.cmd >= OP_RD_LO;
	wire logic [7:0] byte_in     = {sh_q[6:0], din_s_q[1]};

	// Two-stage synchronisers
	always_ff @(posedge ref_clk)
	begin
		sck_s_q <= {sck_s_q[0], spi_sck};
		din_s_q <= {din_s_q[0], spi_din};
		ce_s_q  <= {ce_s_q[0], spi_ce_n};
		sck_p_q <= sck_s_q[1];
		ce_p_q  <= ce_s_q[1];
	end

	// Framing, shifting in on falling and out on rising clock edges
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			bit_q <= 4'h0; txcnt_q <= 4'h0; sh_q <= 16'h0000; tx_q <= 16'h0000;
			cmd_done_q <= 1'b0; extra_q <= 1'b0; spi_dout <= 1'b0;
			lnk.cmd <= 8'hFF; lnk.addr <= 8'h00; lnk.wr_data <= 16'h0000;
			lnk.exec_stb <= 1'b0; lnk.wr_stb <= 1'b0; lnk.wr_first <= 1'b0; lnk.rd_take <= 1'b0;
		end
		else
		begin
			lnk.exec_stb <= 1'b0;
			lnk.wr_stb   <= 1'b0;
			lnk.rd_take  <= 1'b0;
			if (lnk.wr_stb)
			begin
				lnk.addr     <= lnk.addr + 8'h01;
				lnk.wr_first <= 1'b0;
			end
			if (frame_start)
			begin
				bit_q <= 4'h0; txcnt_q <= 4'h0;
				cmd_done_q <= 1'b0; extra_q <= 1'b0; lnk.wr_first <= 1'b1;
			end
			else if (ce_act && sck_fall)
			begin
				sh_q  <= {sh_q[14:0], din_s_q[1]}; // RQ18
				bit_q <= bit_q + 4'h1;
				if (!cmd_done_q && bit_q == 4'h7)
				begin
					lnk.cmd    <= byte_in;
					lnk.addr   <= byte_in;
					cmd_done_q <= 1'b1;
					bit_q      <= 4'h0;
				end
				else if (cmd_done_q)
				begin
					extra_q <= 1'b1;
					if (bit_q == 4'hF)
					begin
						lnk.wr_stb  <= ~is_read;
						lnk.wr_data <= {sh_q[14:0], din_s_q[1]}; // RQ18
					end
				end
			end
			if (ce_act && sck_rise && cmd_done_q && is_read)
			begin
				txcnt_q <= txcnt_q + 4'h1;
				if (txcnt_q == 4'h0)
				begin
					spi_dout    <= lnk.rd_data[15];
					tx_q        <= {lnk.rd_data[14:0], 1'b0};
					lnk.rd_take <= 1'b1;
				end
				else
				begin
					spi_dout <= tx_q[15];
					tx_q     <= {tx_q[14:0], 1'b0};
				end
				if (txcnt_q == 4'hF)
					lnk.addr <= lnk.addr + 8'h01;
			end
			if (frame_end)
			begin
				lnk.exec_stb <= cmd_done_q & ~extra_q; // RQ1
				spi_dout     <= 1'b0;
				cmd_done_q   <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: core/ocd_top.sv
// Opcode command decoder: runs execution opcodes, routes register and flash opcodes.
// Assumes a measurement front end on ref_clk that answers start pulses with done pulses.
//
// Behaviour
// RQ1 - An execution opcode is eight bits alone; it starts after chip enable rises.
// RQ2 - Opcodes 06h to 0Eh: save, three auto sequences, halt, regulator, calibrate.
// RQ3 - B0h..FFh read and 30h..43h write the 16-bit register the opcode names.
// RQ4 - Flash 90h read, 10h write, 13h erase; address to 1FFFh, even for data.
// RQ5 - Opcode 00h launches one upstream flight measurement.
// RQ6 - Upstream hit, mean and wave ratio are stored in upstream results.
// RQ7 - Opcode 01h launches one downstream measurement and stores its results.
// RQ8 - Flight done flag is set only once all results are stored.
// RQ9 - Opcode 02h runs upstream then downstream, starts spaced by the spacing field.
// RQ10 - Differential run stores upstream mean minus downstream mean, then flags done.
// RQ11 - Opcode 03h runs the temperature sequence, storing each port's time.
// RQ12 - Thermal done flag is set after the last temperature port.
// RQ13 - Opcode 04h reloads configuration from the saved nonvolatile copy.
// RQ14 - Opcode 04h clears all results and the status register.
// RQ15 - Host issues 05h after configuring; flight and thermal need it first.
// RQ16 - Initialisation end sets the setup done flag.
// RQ17 - Unlisted opcodes change nothing; host waits for completion before the next.
// RQ18 - Link clock idles low, data sampled on falling edge, most significant bit first.
// RQ19 - Reading status clears it; a flag raised during the read stays set.
// RQ20 - Alert pin asserts while any flag is set and its enable bit is set.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ocd_top
	import ocd_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          srst,
	input  wire logic          spi_sck,
	input  wire logic          spi_din,
	input  wire logic          spi_ce_n,
	output wire logic          spi_dout,
	input  wire logic [7:0]    reg_addr,
	input  wire logic [15:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output var  logic [15:0]   reg_rdata,
	input  wire logic          fe_done,
	input  wire logic [15:0]   fe_hit,
	input  wire logic [15:0]   fe_mean,
	input  wire logic [15:0]   fe_ratio,
	output var  logic          upstream_transmit_pin,
	output var  logic          downstream_transmit_pin,
	output var  logic          temp_start,
	input  wire logic          temp_valid,
	input  wire logic [1:0]    temp_port,
	input  wire logic [15:0]   temp_time,
	input  wire logic          temp_last,
	output var  logic          aux_start,
	output var  logic [7:0]    aux_code,
	input  wire logic          aux_done,
	output var  logic          flash_req,
	output var  ocd_flash_op_t flash_op,
	output var  logic [12:0]   flash_addr,
	output var  logic          alert_n
);
	ocd_link_if lnk ();

	logic [15:0] cfg_q [CFG_N];
	logic [15:0] nv_q [CFG_N];
	logic [15:0] res_q [RES_N];
	logic [15:0] status_q;
	logic [15:0] status_d;
	logic [15:0] set_v;
	logic [15:0] space_cnt_q;
	logic        init_q;
	logic        diff_q;
	ocd_state_t  st_q;
	ocd_state_t  st_d;

	ocd_spi_rx u_spi (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.spi_sck  (spi_sck),
		.spi_din  (spi_din),
		.spi_ce_n (spi_ce_n),
		.spi_dout (spi_dout),
		.lnk      (lnk.spi)
	);

	// Register space shared by read opcodes and the local port
	function automatic logic [15:0] read_word(input logic [7:0] a);
		logic [7:0] ci;
		logic [7:0] ri;
		ci = a - CFG_RD_BASE;
		ri = a - RES_RD_BASE;
		read_word = 16'h0000;
		if (a >= CFG_RD_BASE && a < RES_RD_BASE)
			read_word = cfg_q[ci[4:0]];
		else if (a >= RES_RD_BASE && a < RES_RD_END)
			read_word = res_q[ri[3:0]];
		else if (a == STAT_ADDR)
			read_word = status_q;
	endfunction

	assign lnk.rd_data = read_word(lnk.addr); // RQ3

	// Execution opcode decode, only taken while idle
	wire logic       exec      = lnk.exec_stb && st_q == ST_IDLE; // RQ1 RQ17
	wire logic [7:0] op        = lnk.cmd;
	wire logic       start_up  = exec && init_q && (op == OP_UP || op == OP_DIFF); // RQ5 RQ9 RQ15
	wire logic       start_dn1 = exec && init_q && op == OP_DN; // RQ7 RQ15
	wire logic       start_tmp = exec && init_q && op == OP_TEMP; // RQ11 RQ15
	wire logic       do_reset  = exec && op == OP_RESET;
	wire logic       do_init   = exec && op == OP_INIT;
	wire logic       do_save   = exec && op == OP_SAVE; // RQ2
	wire logic       do_aux    = exec && op >= OP_AUX_LO && op <= OP_AUX_HI; // RQ2

	// Differential spacing between the two launches
	wire logic [2:0]  spacing = cfg_q[CFG_SPACING_IDX][SPACING_LSB +: 3];
	wire logic [15:0] gap_tgt = 16'((16'(spacing) + 16'h0001) * SPACE_UNIT_CYC); // RQ9
	wire logic        gap_ok  = st_q == ST_WAIT && space_cnt_q >= gap_tgt; // RQ9
	wire logic        start_dn = start_dn1 || gap_ok;

	// Completion events
	wire logic        up_fin   = st_q == ST_UP && fe_done;
	wire logic        dn_fin   = st_q == ST_DN && fe_done;
	wire logic        tmp_wr   = st_q == ST_TEMP && temp_valid;
	wire logic        tmp_fin  = tmp_wr && temp_last;
	wire logic        aux_fin  = st_q == ST_AUX && aux_done;
	wire logic [15:0] delta    = res_q[RES_UP_MEAN] - fe_mean; // RQ10
	wire logic [3:0]  tmp_idx  = 4'(RES_TEMP0) + {2'b00, temp_port};

	// Register write decode, opcode path and local port
	wire logic       spi_op_wr  = lnk.cmd >= OP_WR_LO && lnk.cmd <= OP_WR_HI;
	wire logic       spi_cfg_wr = lnk.wr_stb && spi_op_wr && lnk.addr <= OP_WR_HI; // RQ3
	wire logic [7:0] spi_widx   = lnk.addr - OP_WR_LO;
	wire logic       prt_cfg_wr = reg_wr && reg_addr >= OP_WR_LO && reg_addr <= OP_WR_HI;
	wire logic [7:0] prt_widx   = reg_addr - OP_WR_LO;

	// Flash opcode routing on the first word, the address
	wire logic       fl_rd    = lnk.cmd == OP_FL_RD;
	wire logic       fl_wr    = lnk.cmd == OP_FL_WR;
	wire logic       fl_er    = lnk.cmd == OP_FL_ER;
	wire logic [15:0] fl_a    = lnk.wr_data;
	wire logic       fl_aok   = fl_a[15:13] == 3'b000 && (fl_er || !fl_a[0]); // RQ4
	wire logic       fl_go    = lnk.wr_stb && lnk.wr_first && (fl_rd || fl_wr || fl_er) && fl_aok; // RQ4

	// Status flags: set wins over the read clear
	wire logic stat_clr = (lnk.rd_take && lnk.addr == STAT_ADDR) || (reg_rd && reg_addr == STAT_ADDR);
	always_comb
	begin
		set_v              = 16'h0000;
		set_v[FLG_FLIGHT]  = (up_fin && !diff_q) || dn_fin; // RQ8 RQ10
		set_v[FLG_THERMAL] = tmp_fin; // RQ12
		set_v[FLG_SETUP]   = do_init; // RQ16
		set_v[FLG_SAVE]    = do_save;
		set_v[FLG_AUX]     = aux_fin;
		status_d           = (stat_clr ? STAT_RST : status_q) | set_v; // RQ19
		if (do_reset)
			status_d = STAT_RST; // RQ14
	end

	// Sequencer
	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE:
			begin
				if (start_up)
					st_d = ST_UP;
				else if (start_dn1)
					st_d = ST_DN;
				else if (start_tmp)
					st_d = ST_TEMP;
				else if (do_aux)
					st_d = ST_AUX;
			end
			ST_UP:   if (fe_done) st_d = diff_q ? ST_WAIT : ST_IDLE;
			ST_WAIT: if (gap_ok) st_d = ST_DN;
			ST_DN:   if (fe_done) st_d = ST_IDLE;
			ST_TEMP: if (temp_valid && temp_last) st_d = ST_IDLE;
			ST_AUX:  if (aux_done) st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end

	// Control state and launch pulses
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			st_q <= ST_IDLE; diff_q <= 1'b0; init_q <= 1'b0; space_cnt_q <= 16'h0000;
			status_q <= STAT_RST;
			upstream_transmit_pin <= 1'b0; downstream_transmit_pin <= 1'b0;
			temp_start <= 1'b0; aux_start <= 1'b0; aux_code <= 8'h00;
		end
		else
		begin
			st_q     <= st_d;
			status_q <= status_d;
			if (start_up || start_dn1)
				diff_q <= op == OP_DIFF; // RQ9 RQ10
			if (do_init)
				init_q <= 1'b1; // RQ15
			else if (do_reset)
				init_q <= 1'b0;
			space_cnt_q <= start_up ? 16'h0001 : space_cnt_q + {15'h0000, space_cnt_q != 16'hFFFF}; // RQ9
			upstream_transmit_pin   <= start_up; // RQ5
			downstream_transmit_pin <= start_dn; // RQ7
			temp_start <= start_tmp; // RQ11
			aux_start  <= do_aux; // RQ2
			if (do_aux)
				aux_code <= op;
		end
	end

	// Measurement results
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < RES_N; i++)
			if (srst || do_reset)
				res_q[i] <= RES_RST; // RQ14
		if (!srst && !do_reset)
		begin
			if (up_fin)
			begin
				res_q[RES_UP_HIT]   <= fe_hit; // RQ6
				res_q[RES_UP_MEAN]  <= fe_mean;
				res_q[RES_UP_RATIO] <= fe_ratio;
			end
			if (dn_fin)
			begin
				res_q[RES_DN_HIT]   <= fe_hit; // RQ7
				res_q[RES_DN_MEAN]  <= fe_mean;
				res_q[RES_DN_RATIO] <= fe_ratio;
				if (diff_q)
					res_q[RES_DELTA] <= delta; // RQ10
			end
			if (tmp_wr)
				res_q[tmp_idx] <= temp_time; // RQ11
		end
	end

	// Configuration and its saved copy; opcode writes win over the port
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < CFG_N; i++)
		begin
			if (srst)
			begin
				cfg_q[i] <= CFG_RST;
				nv_q[i]  <= CFG_RST;
			end
			else
			begin
				if (do_save)
					nv_q[i] <= cfg_q[i]; // RQ2
				if (do_reset)
					cfg_q[i] <= nv_q[i]; // RQ13
				else if (spi_cfg_wr && spi_widx == 8'(i))
					cfg_q[i] <= lnk.wr_data; // RQ3
				else if (prt_cfg_wr && prt_widx == 8'(i))
					cfg_q[i] <= reg_wdata;
			end
		end
	end

	// Port read data, flash requests and alert pin
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			reg_rdata <= 16'h0000; flash_req <= 1'b0; flash_op <= FL_READ;
			flash_addr <= FLASH_ADDR_RST; alert_n <= 1'b1;
		end
		else
		begin
			reg_rdata <= reg_rd ? read_word(reg_addr) : 16'h0000;
			flash_req <= fl_go; // RQ4
			if (fl_go)
			begin
				flash_op   <= fl_rd ? FL_READ : (fl_wr ? FL_WRITE : FL_ERASE);
				flash_addr <= fl_a[12:0];
			end
			alert_n <= !(status_q != 16'h0000 && cfg_q[CFG_CTRL_IDX][ALERT_EN_BIT]); // RQ20
		end
	end

	AST_NEED_INIT: assert property (@(posedge ref_clk) disable iff (srst) // RQ15
		(upstream_transmit_pin || temp_start) |-> init_q)
		else $error("launch without initialisation");
	AST_UP_STORE: assert property (@(posedge ref_clk) disable iff (srst) // RQ8
		(up_fin && !diff_q) |=> status_q[FLG_FLIGHT] && res_q[RES_UP_MEAN] == $past(fe_mean))
		else $error("upstream result or flag missing");
	AST_DELTA: assert property (@(posedge ref_clk) disable iff (srst) // RQ10
		(dn_fin && diff_q) |=> res_q[RES_DELTA] == $past(delta) && status_q[FLG_FLIGHT])
		else $error("difference not stored");
	AST_SPACING: assert property (@(posedge ref_clk) disable iff (srst) // RQ9
		(downstream_transmit_pin && diff_q) |-> $past(space_cnt_q) >= $past(gap_tgt))
		else $error("downstream launched too early");
	AST_TEMP_FLAG: assert property (@(posedge ref_clk) disable iff (srst) // RQ12
		tmp_fin |=> status_q[FLG_THERMAL] && st_q == ST_IDLE)
		else $error("thermal flag missing");
	AST_RESET_CLR: assert property (@(posedge ref_clk) disable iff (srst) // RQ14
		do_reset |=> status_q == 16'h0000 && res_q[RES_UP_MEAN] == 16'h0000 && !init_q)
		else $error("reset command left state");
	AST_RELOAD: assert property (@(posedge ref_clk) disable iff (srst) // RQ13
		do_reset |=> cfg_q[CFG_CTRL_IDX] == $past(nv_q[CFG_CTRL_IDX]))
		else $error("configuration not reloaded");
	AST_INIT_FLAG: assert property (@(posedge ref_clk) disable iff (srst) // RQ16
		do_init |=> status_q[FLG_SETUP] ##1 init_q)
		else $error("setup flag missing");
	AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (srst) // RQ19
		(stat_clr && set_v[FLG_FLIGHT]) |=> status_q[FLG_FLIGHT])
		else $error("flag lost in status read");
	AST_ALERT: assert property (@(posedge ref_clk) disable iff (srst) // RQ20
		status_q == 16'h0000 [*2] |-> alert_n)
		else $error("alert without flags");
	AST_IGNORE: assert property (@(posedge ref_clk) disable iff (srst) // RQ17
		(lnk.exec_stb && lnk.cmd > OP_AUX_HI) |=> st_q == $past(st_q) && init_q == $past(init_q))
		else $error("unlisted opcode had effect");
endmodule
`default_nettype wire

// file: test/ocd_host_model.sv
// Host serial master model: frames opcodes and data words on the four-wire link.
// Assumes an 80 ns link clock, unrelated in phase to ref_clk, running only inside frames.
`timescale 1ns/1ps
`default_nettype none
module ocd_host_model
(
	output var  logic spi_sck,
	output var  logic spi_din,
	output var  logic spi_ce_n,
	input  wire logic spi_dout
);
	// Idle link: clock low, chip enable released
	initial
	begin
		spi_sck  = 1'b0;
		spi_din  = 1'b0;
		spi_ce_n = 1'b1;
	end

	// Shift n bits from bits[31] down; rd keeps the last 16 bits seen on dout
	task automatic xfer(input logic [31:0] bits, input int n, output logic [15:0] rd);
		rd = 16'h0000;
		#13 spi_ce_n = 1'b0;
		// Data changes with the rising edge, so it stands across the falling sample
		for (int i = 0; i < n; i++)
		begin
			#40 rd = {rd[14:0], spi_dout};
			spi_sck = 1'b1;
			spi_din = bits[31 - i];
			#40 spi_sck = 1'b0;
		end
		#40 rd = {rd[14:0], spi_dout};
		spi_ce_n = 1'b1;
		spi_din = ~spi_din; // Released line shows no stale bit
		#200;
	endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the opcode command decoder.
// Assumes the host model drives the link and local models answer launches and starts.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import ocd_pkg::*;
;
	typedef struct packed {logic [7:0] op; logic [7:0] mask; logic [7:0] ra; logic [15:0] rv;} ocd_row_t;
	logic          ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic          spi_sck, spi_din, spi_ce_n, spi_dout;
	logic [7:0]    reg_addr = 8'h00, aux_code;
	logic [15:0]   reg_wdata = 16'h0000, reg_rdata, rd, temp_time = 16'h0000;
	logic [15:0]   fe_hit = 16'h0000, fe_mean = 16'h0000, fe_ratio = 16'h0000;
	logic          fe_done = 1'b0, temp_valid = 1'b0, temp_last = 1'b0, aux_done = 1'b0;
	logic [1:0]    temp_port = 2'h0;
	logic          upstream_transmit_pin, downstream_transmit_pin, temp_start, aux_start, flash_req, alert_n;
	ocd_flash_op_t flash_op;
	logic [12:0]   flash_addr;
	int            cyc = 0, n_fail = 0, compares = 0, fe_wait = 0, tp = 0, aux_wait = 0;
	int            launches = 0, up_at = 0, dn_at = 0, n_flash = 0, l0;
	ocd_row_t      rows [5] = '{
		'{OP_UP,   8'h01, 8'hC5, 16'h0500},
		'{OP_DN,   8'h01, 8'hC8, 16'h0123},
		'{OP_DIFF, 8'h01, 8'hCA, 16'h03DD},
		'{OP_TEMP, 8'h02, 8'hCB, 16'h0100},
		'{OP_SAVE, 8'h08, 8'hB1, 16'h0002}
	};

	ocd_host_model i_host (.spi_sck, .spi_din, .spi_ce_n, .spi_dout);

	ocd_top i_dut (.ref_clk, .srst, .spi_sck, .spi_din, .spi_ce_n, .spi_dout, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .fe_done, .fe_hit, .fe_mean, .fe_ratio, .upstream_transmit_pin,
		.downstream_transmit_pin, .temp_start, .temp_valid, .temp_port, .temp_time, .temp_last,
		.aux_start, .aux_code, .aux_done, .flash_req, .flash_op, .flash_addr, .alert_n);

	// Reference clock
	always #4 ref_clk = ~ref_clk;

	// Front-end, temperature, aux and flash models plus the hang limit
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		fe_wait <= (upstream_transmit_pin || downstream_transmit_pin) ? 20 : (fe_wait > 0 ? fe_wait - 1 : 0);
		fe_done <= fe_wait == 1;
		if (upstream_transmit_pin || downstream_transmit_pin)
		begin
			launches <= launches + 1;
			fe_mean  <= downstream_transmit_pin ? 16'h0123 : 16'h0500;
			fe_hit   <= downstream_transmit_pin ? 16'h0B0B : 16'h0A0A;
			fe_ratio <= 16'h0C0C;
		end
		if (upstream_transmit_pin)
			up_at <= cyc;
		if (downstream_transmit_pin)
			dn_at <= cyc;
		tp <= temp_start ? 8 : (tp > 0 ? tp - 1 : 0);
		temp_valid <= tp > 0 && tp < 5;
		temp_port <= 2'(4 - tp);
		temp_time <= 16'h0100 + 16'(4 - tp);
		temp_last <= tp == 1;
		aux_wait <= aux_start ? 10 : (aux_wait > 0 ? aux_wait - 1 : 0);
		aux_done <= aux_wait == 1;
		n_flash <= n_flash + int'(flash_req);
		if (cyc == 40000)
		begin
			n_fail++;
			give_verdict();
		end
	end

	// Comparison and report helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Local register port cycles
	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask

	// Link operations
	task automatic exec(input logic [7:0] op);
		i_host.xfer({op, 24'h0}, 8, rd);
	endtask

	task automatic done_chk(input logic [15:0] mask);
		for (int k = 0; k < 3000 && alert_n !== 1'b0; k++)
			@(posedge ref_clk) #1;
		chk({15'h0, alert_n}, 16'h0000);
		rchk(STAT_ADDR, mask);
		rchk(STAT_ADDR, 16'h0000);
		chk({15'h0, alert_n}, 16'h0001);
	endtask

	task automatic fl(input logic [7:0] op, input logic [15:0] a, input logic e);
		int            n0;
		ocd_flash_op_t f;
		n0 = n_flash;
		f = op == OP_FL_RD ? FL_READ : (op == OP_FL_WR ? FL_WRITE : FL_ERASE);
		i_host.xfer({op, a, 8'h00}, 24, rd);
		chk(16'(n_flash - n0), {15'h0, e});
		if (e)
		begin
			chk({3'h0, flash_addr}, a);
			chk({14'h0, flash_op}, {14'h0, f});
		end
	endtask

	// Main sequence: reset, table of opcodes, then the awkward cases
	initial
	begin
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk) #1;
		chk({15'h0, alert_n}, 16'h0001);
		rchk(STAT_ADDR, 16'h0000);
		reg_write(8'h31, 16'h0002);
		reg_write(8'h43, 16'h0001);
		rchk(8'hB1, 16'h0002);
		rchk(8'hC3, 16'h0001);
		rchk(8'h60, 16'h0000);
		exec(OP_UP);
		repeat (300) @(posedge ref_clk);
		chk(16'(launches), 16'h0000);
		exec(OP_INIT);
		done_chk(16'h0004);
		foreach (rows[i])
		begin
			exec(rows[i].op);
			done_chk({8'h00, rows[i].mask});
			rchk(rows[i].ra, rows[i].rv);
			if (rows[i].op == OP_DIFF)
				chk(16'(dn_at - up_at), 16'(3 * SPACE_UNIT_CYC));
		end
		for (int op = 7; op <= 14; op++)
		begin
			exec(8'(op));
			done_chk(16'h0010);
			chk({8'h00, aux_code}, 16'(op));
		end
		// Status read in the very cycle the flight flag is raised
		fork
			exec(OP_UP);
			begin
				@(posedge upstream_transmit_pin);
				repeat (20) @(posedge ref_clk);
				rchk(STAT_ADDR, 16'h0000);
			end
		join
		done_chk(16'h0001);
		l0 = launches;
		exec(8'h0F);
		i_host.xfer({OP_UP, 24'h0}, 9, rd);
		repeat (300) @(posedge ref_clk);
		chk(16'(launches - l0), 16'h0000);
		rchk(STAT_ADDR, 16'h0000);
		i_host.xfer({8'hB1, 24'h0}, 24, rd);
		chk(rd, 16'h0002);
		i_host.xfer({8'h32, 16'h1234, 8'h00}, 24, rd);
		rchk(8'hB2, 16'h1234);
		fl(OP_FL_RD, 16'h0100, 1'b1);
		fl(OP_FL_ER, 16'h0101, 1'b1);
		fl(OP_FL_WR, 16'h0101, 1'b0);
		fl(OP_FL_WR, 16'h1FFE, 1'b1);
		fl(OP_FL_RD, 16'h2000, 1'b0);
		exec(OP_RESET);
		repeat (50) @(posedge ref_clk);
		rchk(8'hC5, 16'h0000);
		rchk(STAT_ADDR, 16'h0000);
		rchk(8'hB1, 16'h0002);
		rchk(8'hB2, 16'h0000);
		rchk(8'hC3, 16'h0001);
		l0 = launches;
		exec(OP_UP);
		repeat (300) @(posedge ref_clk);
		chk(16'(launches - l0), 16'h0000);
		give_verdict();
	end
endmodule
`default_nettype wire
